/* rtl/tsf_status.sv */
// Status word, flags and request logic of the tape controller
module tsf_status
  import tsf_pkg::*;
#(
  parameter int unsigned NUM_UNITS   = 8,
  parameter int unsigned DMISS_LIMIT = DMISS_CYCLES
) (
  input  wire logic                 CLK,
  input  wire logic                 NRST,
  input  wire logic                 CMD_WR,
  input  wire logic [2:0]           CMD_FUNC,
  input  wire logic                 STS_WR,
  input  wire logic [18:35]         STS_WDATA,
  input  wire logic                 DATA_XFER,
  input  wire logic                 WORD_READY,
  input  wire logic                 PH_BLKNUM,
  input  wire logic                 PH_REVCHK,
  input  wire logic                 PH_DATA,
  input  wire logic                 PH_FINAL,
  input  wire logic                 PH_CHKSUM,
  input  wire logic                 PH_GAP,
  input  wire logic                 BLKNUM_DONE,
  input  wire logic                 CHKSUM_DONE,
  input  wire logic                 CHKSUM_BAD,
  input  wire logic                 ALL_MODE_END,
  input  wire logic                 END_ZONE_MARK,
  input  wire logic                 MARK_BAD,
  input  wire logic                 SYNC_MARK,
  input  wire logic                 DELAY_IN,
  input  wire logic                 ACTIVE_IN,
  input  wire logic                 UP_SPEED,
  input  wire logic                 WRITE_LOCK_SW,
  input  wire logic                 TIMING_SW,
  input  wire logic [NUM_UNITS-1:0] UNIT_ANSWER,
  output logic      [0:35]          STATUS_WORD,
  output logic                      FLAG_IRQ,
  output logic                      DATA_IRQ,
  output logic                      TAPE_STOP,
  output logic                      STOP_OTHERS
);

  localparam int unsigned SYNC_W = NUM_UNITS + 2;
  localparam logic [14:0] DMISS_LAST = 15'(DMISS_LIMIT - 1);

  function automatic logic exactly_one(input logic [NUM_UNITS-1:0] v);
    int unsigned n;
    n = 0;
    for (int i = 0; i < NUM_UNITS; i++)
    begin
      n = n + int'(v[i]);
    end
    return n == 1;
  endfunction

  function automatic logic is_data_cmd(input logic [2:0] f);
    return f == TSF_RD_DATA || f == TSF_WR_DATA;
  endfunction

  logic [SYNC_W-1:0] pins_s;
  logic              wlock_s;
  logic              tmsw_s;
  logic [NUM_UNITS-1:0] units_s;

  logic [2:0]        func_r;
  logic [0:5]        en_r;
  logic              fstop_r;
  logic              bnr_r;
  logic              par_r;
  logic              dmiss_r;
  logic              job_r;
  logic              illop_r;
  logic              endz_r;
  logic              blkmiss_r;
  logic              incblk_r;
  logic              mterr_r;
  logic              selerr_r;
  logic              flag_req_r;
  logic              data_req_r;
  logic [14:0]       dmiss_cnt_r;
  logic [0:5]        flags;
  logic [0:35]       status_nxt;
  logic              fstop_wr;
  logic              dmiss_set;
  logic              data_cmd_wr;
  logic              wr_cmd;
  logic              tm_conflict;
  logic              sel_bad;
  logic              in_block;

  // Switches and unit answers arrive from the transports, not from this clock
  tsf_sync2 #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk   (CLK),
    .nrst  (NRST),
    .din   ({WRITE_LOCK_SW, TIMING_SW, UNIT_ANSWER}),
    .dout  (pins_s)
  );

  assign wlock_s = pins_s[SYNC_W-1];
  assign tmsw_s  = pins_s[SYNC_W-2];
  assign units_s = pins_s[NUM_UNITS-1:0];

  assign fstop_wr    = STS_WR && STS_WDATA[W_FSTOP];
  assign data_cmd_wr = CMD_WR && is_data_cmd(CMD_FUNC);
  assign wr_cmd      = CMD_FUNC[2];
  assign tm_conflict = (CMD_FUNC != TSF_NOP) && (tmsw_s != (CMD_FUNC == TSF_WR_TM));
  assign sel_bad     = !exactly_one(units_s);
  assign in_block    = !PH_GAP;
  // Missing stops once function stop is sent
  assign dmiss_set   = data_req_r && !fstop_r && (dmiss_cnt_r == DMISS_LAST);
  assign flags       = {par_r || mterr_r, dmiss_r, job_r, illop_r, endz_r, blkmiss_r}; // R9

  // Function of the last command write
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      func_r <= TSF_NOP;
    else if (CMD_WR)
      func_r <= CMD_FUNC;
  end

  // Enables and function stop; a status write in the clearing cycle still lands
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      en_r    <= '0;
      fstop_r <= 1'b0;
    end
    else if (STS_WR)
    begin
      en_r    <= STS_WDATA[W_EN0 +: NUM_FLAGS]; // R24
      fstop_r <= STS_WDATA[W_FSTOP] || (fstop_r && !CMD_WR);
    end
    else if (CMD_WR)
    begin
      en_r    <= '0; // R23
      fstop_r <= 1'b0;
    end
  end

  // Block number read marker
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      bnr_r <= 1'b0;
    else if (BLKNUM_DONE)
      bnr_r <= 1'b1; // R7
    else if (PH_REVCHK || CMD_WR)
      bnr_r <= 1'b0; // R7
  end

  // Checksum failure memory since the last command write
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      par_r <= 1'b0;
    else if (CHKSUM_BAD)
      par_r <= 1'b1; // R9
    else if (CMD_WR)
      par_r <= 1'b0;
  end

  // Mark track error
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      mterr_r <= 1'b0;
    else if (MARK_BAD || (SYNC_MARK && ACTIVE_IN))
      mterr_r <= 1'b1; // R18
    else if (CMD_WR)
      mterr_r <= 1'b0;
  end

  // Data request and its service timer
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      data_req_r <= 1'b0;
    else if (WORD_READY)
      data_req_r <= 1'b1; // R21
    else if (DATA_XFER || fstop_wr || CMD_WR)
      data_req_r <= 1'b0; // R22
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      dmiss_cnt_r <= '0;
    else if (!data_req_r || WORD_READY || dmiss_set)
      dmiss_cnt_r <= '0;
    else
      dmiss_cnt_r <= dmiss_cnt_r + 15'h0001; // R10
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      dmiss_r <= 1'b0;
    else if (dmiss_set)
      dmiss_r <= 1'b1; // R10
    else if (CMD_WR)
      dmiss_r <= 1'b0;
  end

  // Job done per command class; stop in a gap ends the job at once
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      job_r <= 1'b0;
    else if ((BLKNUM_DONE && (func_r == TSF_RD_BLK || func_r == TSF_WR_BLK))
             || (CHKSUM_DONE && is_data_cmd(func_r) && (fstop_r || dmiss_r))
             || (ALL_MODE_END && (func_r == TSF_RD_ALL || func_r == TSF_WR_ALL))
             || (fstop_wr && PH_GAP))
      job_r <= 1'b1; // R11
    else if (CMD_WR)
      job_r <= 1'b0;
  end

  // Illegal operation and select error, judged on the new command
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      illop_r <= 1'b0;
    else if (CMD_WR)
      illop_r <= (wr_cmd && wlock_s) || tm_conflict || sel_bad; // R12
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      selerr_r <= 1'b0;
    else if (CMD_WR)
      selerr_r <= sel_bad; // R19
  end

  // End zone flag and tape stop
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      endz_r    <= 1'b0;
      TAPE_STOP <= 1'b0;
    end
    else
    begin
      TAPE_STOP <= END_ZONE_MARK; // R13
      if (END_ZONE_MARK)
        endz_r <= 1'b1; // R13
      else if (CMD_WR)
        endz_r <= 1'b0;
    end
  end

  // Block missed; judged on the marker as it stood before this write clears it
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      blkmiss_r <= 1'b0;
    else if (data_cmd_wr && !bnr_r)
      blkmiss_r <= 1'b1; // R8 R14
    else if (CMD_WR)
      blkmiss_r <= 1'b0;
  end

  // Incomplete block, never from inside a gap
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      incblk_r <= 1'b0;
    else if ((fstop_wr || dmiss_set) && in_block)
      incblk_r <= 1'b1; // R17
    else if (CMD_WR)
      incblk_r <= 1'b0;
  end

  // Flag request, also the flag interrupt
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      flag_req_r <= 1'b0;
      FLAG_IRQ   <= 1'b0;
    end
    else
    begin
      flag_req_r <= |(flags & en_r); // R20
      FLAG_IRQ   <= |(flags & en_r); // R20
    end
  end

  // Request outputs and the stop-others pulse
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      DATA_IRQ    <= 1'b0;
      STOP_OTHERS <= 1'b0;
    end
    else
    begin
      DATA_IRQ    <= data_req_r; // R21
      STOP_OTHERS <= STS_WR && STS_WDATA[W_STOPALL];
    end
  end

  // Status word image; phases come from the mark decoder on this clock
  always_comb
  begin
    status_nxt                        = STS_RST; // R25
    status_nxt[S_EN0 +: NUM_FLAGS]    = en_r; // R24
    status_nxt[S_DELAY]               = DELAY_IN;
    status_nxt[S_ACTIVE]              = ACTIVE_IN;
    status_nxt[S_UPSPEED]             = UP_SPEED;
    status_nxt[S_BLKNUM]              = PH_BLKNUM; // R1
    status_nxt[S_REVCHK]              = PH_REVCHK; // R2
    status_nxt[S_DATA]                = PH_DATA && !PH_FINAL; // R3
    status_nxt[S_FINAL]               = PH_FINAL; // R4
    status_nxt[S_CHKSUM]              = PH_CHKSUM; // R5
    status_nxt[S_GAP]                 = PH_GAP; // R6
    status_nxt[S_BNR]                 = bnr_r; // R7
    status_nxt[S_FSTOP]               = fstop_r;
    status_nxt[S_FLAG0 +: NUM_FLAGS]  = flags;
    status_nxt[S_WLOCK]               = wlock_s; // R15
    status_nxt[S_TMSW]                = tmsw_s; // R16
    status_nxt[S_INCBLK]              = incblk_r;
    status_nxt[S_MTERR]               = mterr_r;
    status_nxt[S_SELERR]              = selerr_r;
    status_nxt[S_FLAGREQ]             = flag_req_r;
    status_nxt[S_DATAREQ]             = data_req_r;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      STATUS_WORD <= STS_RST;
    else
      STATUS_WORD <= status_nxt;
  end

  property p_phase_bits;
    @(posedge CLK) disable iff (!NRST)
    ##1 STATUS_WORD[S_BLKNUM] == $past(PH_BLKNUM) && STATUS_WORD[S_GAP] == $past(PH_GAP);
  endproperty
  a_phase_bits: assert property (p_phase_bits) else $error("phase bit mismatch"); // R1

  property p_final_excl;
    @(posedge CLK) disable iff (!NRST)
    PH_FINAL |=> STATUS_WORD[S_FINAL] && !STATUS_WORD[S_DATA];
  endproperty
  a_final_excl: assert property (p_final_excl) else $error("data bit on during final"); // R4

  property p_unused;
    @(posedge CLK) disable iff (!NRST)
    !STATUS_WORD[16] && !STATUS_WORD[27] && STATUS_WORD[30:33] == 4'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused status bit set"); // R25

  property p_blk_miss;
    @(posedge CLK) disable iff (!NRST)
    data_cmd_wr && !bnr_r |=> blkmiss_r ##1 STATUS_WORD[23];
  endproperty
  a_blk_miss: assert property (p_blk_miss) else $error("block missed not set"); // R8

  property p_cmd_clear;
    @(posedge CLK) disable iff (!NRST)
    CMD_WR && !STS_WR && !END_ZONE_MARK |=> en_r == 6'h00 && !endz_r && !fstop_r;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("command write left bits set"); // R23

  property p_readback;
    @(posedge CLK) disable iff (!NRST)
    STS_WR |=> ##1 STATUS_WORD[0:5] == $past(STS_WDATA[18:23], 2);
  endproperty
  a_readback: assert property (p_readback) else $error("enable readback wrong"); // R24

  property p_dreq_set;
    @(posedge CLK) disable iff (!NRST)
    WORD_READY |=> data_req_r ##1 DATA_IRQ;
  endproperty
  a_dreq_set: assert property (p_dreq_set) else $error("data request not raised"); // R21

  property p_dreq_clr;
    @(posedge CLK) disable iff (!NRST)
    data_req_r && (DATA_XFER || fstop_wr) && !WORD_READY |=> !data_req_r;
  endproperty
  a_dreq_clr: assert property (p_dreq_clr) else $error("data request not cleared"); // R22

  property p_dmiss;
    @(posedge CLK) disable iff (!NRST)
    dmiss_set |=> dmiss_r;
  endproperty
  a_dmiss: assert property (p_dmiss) else $error("data missed not set"); // R10

  property p_dmiss_early;
    @(posedge CLK) disable iff (!NRST)
    $rose(dmiss_r) |-> $past(dmiss_cnt_r) == DMISS_LAST;
  endproperty
  a_dmiss_early: assert property (p_dmiss_early) else $error("data missed at wrong time"); // R10

  property p_flag_req;
    @(posedge CLK) disable iff (!NRST)
    ##1 FLAG_IRQ == $past(|(flags & en_r)) && flag_req_r == FLAG_IRQ;
  endproperty
  a_flag_req: assert property (p_flag_req) else $error("flag request mismatch"); // R20

  property p_end_zone;
    @(posedge CLK) disable iff (!NRST)
    END_ZONE_MARK |=> TAPE_STOP && endz_r;
  endproperty
  a_end_zone: assert property (p_end_zone) else $error("end zone not handled"); // R13

  property p_inc_gap;
    @(posedge CLK) disable iff (!NRST)
    !incblk_r && PH_GAP |=> !incblk_r;
  endproperty
  a_inc_gap: assert property (p_inc_gap) else $error("incomplete set in gap"); // R17

endmodule

/* rtl/tsf_pkg.sv */
// Package of constants for the tape status and flag block
// Summary of operation
// [R1] Bit 9 reads one while a block number field is being read.
// [R2] Bit 10 reads one while the reverse checksum field is handled.
// [R3] Bit 11 reads one while data words are handled, except the final word.
// [R4] Bit 12 reads one during the last word; bit 11 then reads zero.
// [R5] Bit 13 reads one while the final checksum field is handled.
// [R6] Bit 14 reads one while the tape is in an inter-block gap.
// [R7] Bit 15 sets on block number read, clears when reverse-check phase starts.
// [R8] Read or write data command with bit 15 clear sets block missed.
// [R9] Parity error reads one after any checksum failure or with mark error set.
// [R10] Data missed sets when a data request waits 266 us unserviced.
// [R11] Job done sets per command class: block number, checksum, or all-mode end.
// [R12] Illegal operation sets on write lock, timing switch or select conflict.
// [R13] End zone mark sets the end zone flag and stops the tape.
// [R14] Block missed sets when a data command comes too late for the block.
// [R15] Bit 24 mirrors the selected transport's write lock switch.
// [R16] Bit 25 mirrors the timing and mark track write switch.
// [R17] Incomplete block sets on stop or data missed inside a block only.
// [R18] Mark track error sets on invalid mark code or run into sync mark.
// [R19] Select error sets when zero or several units answer the number.
// [R20] Flag request is the OR of enabled flags 18 to 23; it drives flag interrupt.
// [R21] Data request sets on word ready or word needed; it drives data interrupt.
// [R22] Transferring the word or function stop clears the data request.
// [R23] A command register write clears the enables, function stop, bit 15, data request and the latched event flags; bits 21 and 29 are judged anew instead.
// [R24] Enables written at bits 18 to 23 read back at bits 0 to 5.
// [R25] Unused bits 16, 27 and 30 to 33 read as zero.
package tsf_pkg;

  localparam int unsigned STS_W          = 36;
  localparam int unsigned NUM_FLAGS      = 6;
  localparam logic [35:0] STS_RST        = 36'h000000000;

  // Status word positions, bit 0 is the most significant
  localparam int unsigned S_EN0          = 0;
  localparam int unsigned S_DELAY        = 6;
  localparam int unsigned S_ACTIVE       = 7;
  localparam int unsigned S_UPSPEED      = 8;
  localparam int unsigned S_BLKNUM       = 9;
  localparam int unsigned S_REVCHK       = 10;
  localparam int unsigned S_DATA         = 11;
  localparam int unsigned S_FINAL        = 12;
  localparam int unsigned S_CHKSUM       = 13;
  localparam int unsigned S_GAP          = 14;
  localparam int unsigned S_BNR          = 15;
  localparam int unsigned S_FSTOP        = 17;
  localparam int unsigned S_FLAG0        = 18;
  localparam int unsigned S_WLOCK        = 24;
  localparam int unsigned S_TMSW         = 25;
  localparam int unsigned S_INCBLK       = 26;
  localparam int unsigned S_MTERR        = 28;
  localparam int unsigned S_SELERR       = 29;
  localparam int unsigned S_FLAGREQ      = 34;
  localparam int unsigned S_DATAREQ      = 35;

  // Status write positions
  localparam int unsigned W_EN0          = 18;
  localparam int unsigned W_STOPALL      = 34;
  localparam int unsigned W_FSTOP        = 35;

  // Data request service limit
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned DMISS_TIME_NS  = 266000;
  localparam int unsigned DMISS_CYCLES   = (DMISS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0]
  {
    TSF_NOP     = 3'h0,
    TSF_RD_ALL  = 3'h1,
    TSF_RD_BLK  = 3'h2,
    TSF_RD_DATA = 3'h3,
    TSF_WR_TM   = 3'h4,
    TSF_WR_ALL  = 3'h5,
    TSF_WR_BLK  = 3'h6,
    TSF_WR_DATA = 3'h7
  } tsf_func_t;

endpackage

/* rtl/tsf_sync2.sv */
// Two flip-flop synchroniser bank for switch and pin levels
module tsf_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule

/* testbench/tsf_host.sv */
// Behavioural host that answers data requests from the status block
module tsf_host
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       data_irq,
  input  wire logic       answer_en,
  input  wire logic [7:0] answer_delay,
  output logic            data_xfer
);
  timeunit 1ns;
  timeprecision 1ps;

  // Lets the request drop first so one request is never answered twice
  always
  begin
    data_xfer = 1'b0;
    while (data_irq === 1'b1) @(negedge clk);
    @(negedge clk);
    while (!(nrst === 1'b1 && answer_en === 1'b1 && data_irq === 1'b1)) @(negedge clk);
    repeat (answer_delay) @(negedge clk);
    data_xfer = 1'b1;
    @(negedge clk);
  end
endmodule

/* testbench/tape_control_status_flags_tb.sv */
// Self-checking bench for the tape status and flag block
module tape_control_status_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tsf_pkg::*;

  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cmd_wr = 1'b0;
  logic [2:0]  cmd_func = 3'h0;
  logic        sts_wr = 1'b0;
  logic [17:0] sts_wdata = 18'h00000;
  logic [7:0]  ev = 8'h00;
  logic [5:0]  ph = 6'h00;
  logic [2:0]  lvl = 3'h0;
  logic        wlock = 1'b0;
  logic        tsw = 1'b0;
  logic [7:0]  units = 8'h01;
  logic        ans_en = 1'b1;
  logic        xfer;
  logic [0:35] sw;
  logic        flag_irq;
  logic        data_irq;
  logic        tape_stop;
  logic        stop_others;
  int          stops = 0;
  int          others = 0;
  int          errors = 0;
  int          checked = 0;

  always #5 clk = ~clk;

  // Event index: 0 blknum, 1 chksum, 2 chksum bad, 3 all end, 4 end zone,
  // 5 mark bad, 6 sync mark, 7 word ready
  tsf_status #(.NUM_UNITS(8), .DMISS_LIMIT(20)) dut
  (
    .CLK(clk), .NRST(nrst), .CMD_WR(cmd_wr), .CMD_FUNC(cmd_func),
    .STS_WR(sts_wr), .STS_WDATA(sts_wdata), .DATA_XFER(xfer),
    .WORD_READY(ev[7]), .PH_BLKNUM(ph[5]), .PH_REVCHK(ph[4]),
    .PH_DATA(ph[3]), .PH_FINAL(ph[2]), .PH_CHKSUM(ph[1]), .PH_GAP(ph[0]),
    .BLKNUM_DONE(ev[0]), .CHKSUM_DONE(ev[1]), .CHKSUM_BAD(ev[2]),
    .ALL_MODE_END(ev[3]), .END_ZONE_MARK(ev[4]), .MARK_BAD(ev[5]),
    .SYNC_MARK(ev[6]), .DELAY_IN(lvl[2]), .ACTIVE_IN(lvl[1]),
    .UP_SPEED(lvl[0]), .WRITE_LOCK_SW(wlock), .TIMING_SW(tsw),
    .UNIT_ANSWER(units), .STATUS_WORD(sw), .FLAG_IRQ(flag_irq),
    .DATA_IRQ(data_irq), .TAPE_STOP(tape_stop), .STOP_OTHERS(stop_others)
  );

  tsf_host host
  (
    .clk(clk), .nrst(nrst), .data_irq(data_irq), .answer_en(ans_en),
    .answer_delay(8'h05), .data_xfer(xfer)
  );

  // Both stops are single-cycle pulses, so they are counted as they pass
  always @(posedge clk)
  begin
    if (tape_stop === 1'b1)
      stops <= stops + 1;
    if (stop_others === 1'b1)
      others <= others + 1;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic cmd(input logic [2:0] f);
    @(negedge clk);
    cmd_wr = 1'b1;
    cmd_func = f;
    @(negedge clk);
    cmd_wr = 1'b0;
    wt(4);
  endtask

  task automatic sts(input logic [17:0] d);
    @(negedge clk);
    sts_wr = 1'b1;
    sts_wdata = d;
    @(negedge clk);
    sts_wr = 1'b0;
    wt(4);
  endtask

  task automatic pulse(input int i);
    @(negedge clk);
    ev[i] = 1'b1;
    @(negedge clk);
    ev[i] = 1'b0;
    wt(4);
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    end_sim;
  end

  initial
  begin
    wt(6);
    nrst = 1'b1;
    wt(3);
    chk(sw, 36'h0);
    sts(18'h3F000);
    chk(sw[0:5], 6'h3F);
    for (int i = 0; i < 6; i++)
    begin
      ph = 6'h20 >> i;
      wt(3);
      chk(sw[9:14], ph);
    end
    ph = 6'h0C;
    wt(3);
    chk(sw[9:14], 6'h04);
    ph = 6'h00;
    cmd(3'h2);
    chk({sw[0:5], sw[21]}, 7'h00);
    pulse(0);
    chk({sw[15], sw[20]}, 2'h3);
    sts(18'h3F000);
    chk({flag_irq, sw[34]}, 2'h3);
    cmd(3'h3);
    chk(sw[23], 1'b0);
    cmd(3'h7);
    chk(sw[23], 1'b1);
    pulse(0);
    ph = 6'h10;
    wt(3);
    chk(sw[15], 1'b0);
    ph = 6'h00;
    cmd(3'h0);
    pulse(2);
    chk(sw[18], 1'b1);
    cmd(3'h0);
    chk(sw[18], 1'b0);
    lvl = 3'h7;
    pulse(5);
    chk({sw[6:8], sw[18], sw[28]}, 5'h1F);
    cmd(3'h0);
    pulse(6);
    chk(sw[28], 1'b1);
    lvl = 3'h0;
    // Prompt host: request seen, then answered well inside the limit
    cmd(3'h3);
    pulse(7);
    chk({data_irq, sw[35]}, 2'h3);
    wt(12);
    chk({sw[35], sw[19]}, 2'h0);
    ans_en = 1'b0;
    pulse(7);
    wt(6);
    chk(sw[19], 1'b0);
    wt(20);
    chk({sw[19], sw[26], sw[35]}, 3'h7);
    sts(18'h00001);
    chk({sw[35], sw[17]}, 2'h1);
    pulse(1);
    chk(sw[20], 1'b1);
    cmd(3'h3);
    ph = 6'h01;
    pulse(7);
    wt(30);
    chk({sw[19], sw[26]}, 2'h2);
    sts(18'h00001);
    chk(sw[20], 1'b1);
    ph = 6'h00;
    ans_en = 1'b1;
    cmd(3'h0);
    pulse(4);
    chk({sw[22], stops == 1, flag_irq, others == 0}, 4'hD);
    sts(18'h02002);
    chk({flag_irq, others == 1}, 2'h3);
    wlock = 1'b1;
    wt(4);
    chk(sw[24], 1'b1);
    cmd(3'h7);
    chk(sw[21], 1'b1);
    wlock = 1'b0;
    tsw = 1'b1;
    wt(4);
    chk(sw[25], 1'b1);
    cmd(3'h1);
    chk(sw[21], 1'b1);
    cmd(3'h4);
    chk(sw[21], 1'b0);
    tsw = 1'b0;
    units = 8'h00;
    wt(4);
    cmd(3'h2);
    chk({sw[21], sw[29]}, 2'h3);
    units = 8'h03;
    wt(4);
    cmd(3'h2);
    chk({sw[21], sw[29]}, 2'h3);
    units = 8'h01;
    wt(4);
    cmd(3'h1);
    chk({sw[21], sw[29]}, 2'h0);
    pulse(3);
    chk(sw[20], 1'b1);
    cmd(3'h6);
    pulse(0);
    chk({sw[15], sw[20], sw[21]}, 3'h6);
    cmd(3'h5);
    pulse(0);
    chk(sw[20], 1'b0);
    pulse(3);
    chk(sw[20], 1'b1);
    chk({sw[16], sw[27], sw[30:33]}, 6'h00);
    end_sim;
  end
endmodule
